// [dv/hbd_host_model.sv]
// Bus master model: drives one aligned access at a time on the data window.
// Assumes one-cycle win_sel pulses and win_ack within three edges.
`timescale 1ns/1ps
module hbd_host_model (
  // Clock
  input wire logic clk_sys,
  // Window bus
  output logic win_sel,
  output logic win_write,
  output logic [2:0] win_addr,
  output logic [3:0] byte_lane_select,
  output logic [31:0] win_wdata,
  input wire logic [31:0] win_rdata,
  input wire logic win_ack
);
  // Idle bus at time zero, window offset always aligned
  initial begin
    win_sel = 1'b0;
    win_write = 1'b0;
    win_addr = 3'h0;
    byte_lane_select = 4'h0;
    win_wdata = 32'h0;
  end

  // One access: pulse, scramble released data, bounded wait for ack
  task automatic xfer(input logic wr, input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge clk_sys);
    #1;
    win_sel = 1'b1;
    win_write = wr;
    byte_lane_select = be;
    win_wdata = d;
    @(posedge clk_sys);
    #1;
    win_sel = 1'b0;
    win_wdata = ~d;
    ok = 1'b0;
    q = 32'h0;
    for (n = 0; n < 3 && !ok; n++) begin
      if (win_ack === 1'b1) begin
        ok = 1'b1;
        q = win_rdata;
      end else begin
        @(posedge clk_sys);
        #1;
      end
    end
  endtask
endmodule

// [dv/host_buffer_data_port_tb.sv]
// Testbench for the buffer data window: write, read, length and resume.
// Assumes a 32-bit bus; the bench plays the card-side byte stream.
`timescale 1ns/1ps
module host_buffer_data_port_tb;
  import hbd_pkg::*;
  logic clk_sys, reset_n, blk_len_write, data_line_in_use, xfer_start, xfer_dir;
  logic data_line_reset, card_fill_valid, card_drain_req, resume_resp_valid;
  logic resume_data_flag, resume_4bit_mode, win_sel, win_write, win_ack;
  logic buffer_write_enable, buffer_read_enable, card_block_ready;
  logic suspend_resume_support, xfer_halted, int_cycle_start;
  logic [11:0] blk_len_wdata, blk_len, saved_len;
  logic [7:0] card_fill_data, card_drain_data;
  logic [2:0] win_addr;
  logic [3:0] byte_lane_select;
  logic [31:0] win_wdata, win_rdata, q;
  int fail_count, check_count, i, c;
  logic [7:0] wbytes [6] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'hb5};

  // Design and bus master
  hbd_data_port uut (.clk_sys, .reset_n, .win_sel, .win_write, .win_addr,
    .byte_lane_select, .win_wdata, .win_rdata, .win_ack, .blk_len_write,
    .blk_len_wdata, .blk_len, .data_line_in_use, .xfer_start, .xfer_dir,
    .data_line_reset, .buffer_write_enable, .buffer_read_enable, .card_block_ready,
    .suspend_resume_support, .card_fill_valid, .card_fill_data, .card_drain_req,
    .card_drain_data, .resume_resp_valid, .resume_data_flag, .resume_4bit_mode,
    .xfer_halted, .int_cycle_start);
  hbd_host_model host (.clk_sys, .win_sel, .win_write, .win_addr,
    .byte_lane_select, .win_wdata, .win_rdata, .win_ack);

  // Clock
  always #20 clk_sys = ~clk_sys;

  // Compare and count
  task check(string nm, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Window access; a missing ack ends the run
  task acc(logic wr, logic [3:0] be, logic [31:0] d);
    logic ok;
    host.xfer(wr, be, d, q, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      $display("ERROR win_ack expected 1 seen 0");
      end_of_test;
    end
  endtask

  task t_reset;
    check("blk_len", 32'(blk_len), 32'(HBD_BLK_LEN_RST));
    check("susp_cap", 32'(suspend_resume_support), 32'h1);
    check("wr_en", 32'(buffer_write_enable), 32'h0);
    $display("test reset done");
  endtask

  task t_len;
    blk_len_wdata = 12'h006;
    pulse(blk_len_write);
    cyc(1);
    check("blk_len", 32'(blk_len), 32'h6);
    data_line_in_use = 1'b1;
    blk_len_wdata = 12'h009;
    pulse(blk_len_write);
    cyc(1);
    check("blk_len busy", 32'(blk_len), 32'h6);
    data_line_in_use = 1'b0;
    $display("test length done");
  endtask

  task t_write;
    xfer_dir = 1'b0;
    pulse(xfer_start);
    cyc(1);
    check("wr_en", 32'(buffer_write_enable), 32'h1);
    acc(1'b1, 4'h5, 32'hdeadbeef);
    check("bad be rdata", q, 32'h0);
    acc(1'b1, HBD_BE_L0, 32'ha3a2a1a0);
    acc(1'b1, HBD_BE_L1, 32'ha3a2a1a0);
    acc(1'b1, HBD_BE_L2, 32'ha3a2a1a0);
    acc(1'b1, HBD_BE_L3, 32'ha3a2a1a0);
    acc(1'b1, HBD_BE_ALL, 32'hb7b6b5a4);
    cyc(2);
    check("wr_en end", 32'(buffer_write_enable), 32'h0);
    check("card own", 32'(card_block_ready), 32'h1);
    for (i = 0; i < 6; i++) begin
      card_drain_req = 1'b1;
      cyc(1);
      card_drain_req = 1'b0;
      check("drain byte", 32'(card_drain_data), 32'(wbytes[i]));
      cyc(1);
    end
    cyc(1);
    check("wr_en again", 32'(buffer_write_enable), 32'h1);
    $display("test write done");
  endtask

  task t_read;
    pulse(data_line_reset);
    xfer_dir = 1'b1;
    pulse(xfer_start);
    cyc(1);
    check("card own", 32'(card_block_ready), 32'h1);
    for (i = 0; i < 6; i++) begin
      card_fill_data = 8'hc0 + 8'(i);
      pulse(card_fill_valid);
      card_fill_data = ~card_fill_data;
      cyc(1);
    end
    check("rd_en", 32'(buffer_read_enable), 32'h1);
    acc(1'b0, 4'h5, 32'h0);
    check("bad be rd", q, 32'h0);
    acc(1'b0, HBD_BE_LO, 32'h0);
    check("rd lo", q & 32'h0000ffff, 32'h0000c1c0);
    acc(1'b0, HBD_BE_HI, 32'h0);
    check("rd hi", q & 32'hffff0000, 32'hc3c20000);
    acc(1'b0, HBD_BE_ALL, 32'h0);
    check("rd last", q & 32'h0000ffff, 32'h0000c5c4);
    cyc(2);
    check("rd_en end", 32'(buffer_read_enable), 32'h0);
    $display("test read done");
  endtask

  task t_resume;
    saved_len = blk_len;
    resume_4bit_mode = 1'b1;
    resume_data_flag = 1'b0;
    pulse(resume_resp_valid);
    c = 0;
    for (i = 0; i < 3; i++) begin
      if (int_cycle_start === 1'b1) c++;
      cyc(1);
    end
    check("int pulses", 32'(c), 32'h1);
    check("halted", 32'(xfer_halted), 32'h1);
    check("rd_en halt", 32'(buffer_read_enable), 32'h0);
    // Another command's length, then restore before resuming
    blk_len_wdata = 12'h010;
    pulse(blk_len_write);
    cyc(1);
    blk_len_wdata = saved_len;
    pulse(blk_len_write);
    cyc(1);
    check("len restored", 32'(blk_len), 32'h6);
    resume_data_flag = 1'b1;
    pulse(resume_resp_valid);
    cyc(1);
    check("resumed", 32'(xfer_halted), 32'h0);
    $display("test resume done");
  endtask

  // Main sequence
  initial begin
    {clk_sys, reset_n, blk_len_write, data_line_in_use, xfer_start, xfer_dir} = '0;
    {data_line_reset, card_fill_valid, card_drain_req, resume_resp_valid} = '0;
    {resume_data_flag, resume_4bit_mode, blk_len_wdata, card_fill_data} = '0;
    fail_count = 0;
    check_count = 0;
    cyc(20);
    reset_n = 1'b1;
    cyc(2);
    t_reset;
    t_len;
    t_write;
    t_read;
    t_resume;
    end_of_test;
  end
endmodule

// [inc/hbd_pkg.sv]
// Shared constants and types for the host buffer data window.
// Assumes one system clock; the card-side engine is outside this block.
// Operation
// - Buffer reachable only through one 32-bit window.
// - Hidden pointer advances by bytes moved.
// - Pointer works on 8/16/32/64-bit buses.
// - Byte position from address bits and lanes.
// - Lowest lane select unused on 8-bit bus.
// - Accept all, pair and single lane patterns.
// - Buffer holds data up to block length.
// - Write-space flag drops at block length.
// - Excess bytes of last write dropped.
// - Excess bytes of last read undefined.
// - Read-data flag drops at block length.
// - Suspend/resume support readable as capability bit.
// - Resume flag 0 halts data, starts interrupt in 4-bit mode.
// - Length writes ignored while data line busy.
package hbd_pkg;
  // Block length register
  localparam int HBD_BLK_LEN_W = 12;
  localparam logic [11:0] HBD_BLK_LEN_RST = 12'h200;
  // Window geometry
  localparam int HBD_LANES = 4;
  localparam int HBD_BYTE_W = 8;
  localparam logic [2:0] HBD_CNT_4 = 3'h4;
  localparam logic [2:0] HBD_CNT_2 = 3'h2;
  localparam logic [2:0] HBD_CNT_1 = 3'h1;
  localparam logic [2:0] HBD_CNT_0 = 3'h0;
  // Supported lane patterns
  localparam logic [3:0] HBD_BE_ALL = 4'hf;
  localparam logic [3:0] HBD_BE_LO = 4'h3;
  localparam logic [3:0] HBD_BE_HI = 4'hc;
  localparam logic [3:0] HBD_BE_L0 = 4'h1;
  localparam logic [3:0] HBD_BE_L1 = 4'h2;
  localparam logic [3:0] HBD_BE_L2 = 4'h4;
  localparam logic [3:0] HBD_BE_L3 = 4'h8;
  // System bus widths
  localparam int HBD_BUS_8 = 8;
  localparam int HBD_BUS_16 = 16;
  localparam int HBD_BUS_32 = 32;
  localparam int HBD_BUS_64 = 64;
  // Transfer direction and buffer owner
  typedef enum logic {HBD_DIR_WRITE, HBD_DIR_READ} hbd_dir_t;
  typedef enum logic [1:0] {HBD_IDLE, HBD_HOST, HBD_CARD} hbd_state_t;
endpackage

// [logic/hbd_data_port.sv]
// Buffer data window with hidden pointer and block flags.
// Assumes the card-side engine moves bytes one per cycle when owner.
`timescale 1ns/1ps
module hbd_data_port #(
  parameter int BUS_WIDTH = 32,
  parameter int MAX_BLK = 512,
  parameter logic WIN_A2 = 1'b0,
  parameter logic SUSP_RES_SUPPORT = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // System bus access to the data window
  input wire logic win_sel,
  input wire logic win_write,
  input wire logic [2:0] win_addr,
  input wire logic [3:0] byte_lane_select,
  input wire logic [31:0] win_wdata,
  output logic [31:0] win_rdata,
  output logic win_ack,
  // Transfer control
  input wire logic blk_len_write,
  input wire logic [hbd_pkg::HBD_BLK_LEN_W-1:0] blk_len_wdata,
  output logic [hbd_pkg::HBD_BLK_LEN_W-1:0] blk_len,
  input wire logic data_line_in_use,
  input wire logic xfer_start,
  input wire logic xfer_dir,
  input wire logic data_line_reset,
  // Status
  output logic buffer_write_enable,
  output logic buffer_read_enable,
  output logic card_block_ready,
  output logic suspend_resume_support,
  // Card-side byte stream
  input wire logic card_fill_valid,
  input wire logic [7:0] card_fill_data,
  input wire logic card_drain_req,
  output logic [7:0] card_drain_data,
  // Resume handling
  input wire logic resume_resp_valid,
  input wire logic resume_data_flag,
  input wire logic resume_4bit_mode,
  output logic xfer_halted,
  output logic int_cycle_start
);
  import hbd_pkg::*;

  localparam int PW = $clog2(MAX_BLK) + 1;

  hbd_state_t state;
  hbd_dir_t dir;
  logic [PW-1:0] ptr;
  logic [PW-1:0] card_ptr;
  logic [7:0] buf_mem [0:MAX_BLK-1];

  wire [3:0] lane_mask;
  wire [1:0] lane_first;
  wire [2:0] lane_count;
  wire [1:0] data_shift;
  wire [31:0] lane_wdata;
  wire pattern_ok;

  hbd_lane_decode #(
    .BUS_WIDTH(BUS_WIDTH)
  ) u_decode (
    .win_addr(win_addr),
    .byte_lane_select(byte_lane_select),
    .win_wdata(win_wdata),
    .lane_mask(lane_mask),
    .lane_first(lane_first),
    .lane_count(lane_count),
    .data_shift(data_shift),
    .lane_wdata(lane_wdata),
    .pattern_ok(pattern_ok)
  );

  // Effective length bounded by buffer size
  wire [11:0] max_len12 = 12'(MAX_BLK);
  wire [11:0] eff_len12 = (blk_len > max_len12) ? max_len12 : blk_len;
  wire [PW-1:0] eff_len = eff_len12[PW-1:0];
  wire [PW-1:0] remain = eff_len - ptr;
  wire [PW-1:0] count_w = {{(PW-3){1'b0}}, lane_count};
  wire [PW-1:0] adv = (count_w > remain) ? remain : count_w;
  wire [PW-1:0] ptr_sum = ptr + adv;

  // Window hit and accepted access
  wire addr_hit = (BUS_WIDTH == HBD_BUS_64) || (win_addr[2] == WIN_A2);
  wire dir_ok = win_write ? (dir == HBD_DIR_WRITE) : (dir == HBD_DIR_READ);
  wire win_fire = win_sel && addr_hit && pattern_ok && dir_ok && (state == HBD_HOST);
  wire host_end = win_fire && (ptr_sum >= eff_len);
  wire card_fire = (state == HBD_CARD) &&
                   ((dir == HBD_DIR_READ) ? card_fill_valid : card_drain_req);
  wire card_end = card_fire && (card_ptr + 1'b1 >= eff_len);
  wire halt_now = resume_resp_valid && !resume_data_flag;

  // Per-lane buffer address and read data
  wire [3:0] lane_live;
  wire [PW-1:0] lane_idx [0:HBD_LANES-1];
  wire [31:0] rd_win;
  for (genvar i = 0; i < HBD_LANES; i++) begin : g_lane
    wire [1:0] rel = 2'(i) - lane_first;
    assign lane_idx[i] = ptr + {{(PW-2){1'b0}}, rel};
    assign lane_live[i] = lane_mask[i] && (lane_idx[i] < eff_len);
    assign rd_win[i*HBD_BYTE_W +: HBD_BYTE_W] = lane_live[i] ?
        buf_mem[lane_idx[i][PW-2:0]] : 8'h00;
  end

  // Buffer storage, host lanes or card stream
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < HBD_LANES; i++) begin
      if (win_fire && win_write && lane_live[i]) begin
        buf_mem[lane_idx[i][PW-2:0]] <= lane_wdata[i*HBD_BYTE_W +: HBD_BYTE_W];
      end
    end
    if (card_fire && dir == HBD_DIR_READ) begin
      buf_mem[card_ptr[PW-2:0]] <= card_fill_data;
    end
  end

  // Window answer, one cycle after select
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      win_ack <= 1'b0;
      win_rdata <= 32'h0000_0000;
    end else begin
      win_ack <= win_sel;
      win_rdata <= (win_fire && !win_write) ? (rd_win >> {data_shift, 3'b000}) : 32'h0000_0000;
    end
  end

  // Block length, write protected while data line busy
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      blk_len <= HBD_BLK_LEN_RST;
    end else if (blk_len_write && !data_line_in_use) begin
      blk_len <= blk_len_wdata;
    end
  end

  // Capability bit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      suspend_resume_support <= 1'b0;
    end else begin
      suspend_resume_support <= SUSP_RES_SUPPORT;
    end
  end

  // Buffer ownership, pointers and flags
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= HBD_IDLE;
      dir <= HBD_DIR_WRITE;
      ptr <= '0;
      card_ptr <= '0;
      buffer_write_enable <= 1'b0;
      buffer_read_enable <= 1'b0;
      card_block_ready <= 1'b0;
      card_drain_data <= 8'h00;
      xfer_halted <= 1'b0;
      int_cycle_start <= 1'b0;
    end else begin
      int_cycle_start <= halt_now && resume_4bit_mode;
      if (data_line_reset || halt_now) begin
        state <= HBD_IDLE;
        ptr <= '0;
        card_ptr <= '0;
        buffer_write_enable <= 1'b0;
        buffer_read_enable <= 1'b0;
        card_block_ready <= 1'b0;
        xfer_halted <= halt_now;
      end else begin
        if (resume_resp_valid) begin
          xfer_halted <= 1'b0;
        end
        case (state)
          HBD_IDLE: begin
            if (xfer_start) begin
              dir <= xfer_dir ? HBD_DIR_READ : HBD_DIR_WRITE;
              ptr <= '0;
              card_ptr <= '0;
              state <= xfer_dir ? HBD_CARD : HBD_HOST;
              buffer_write_enable <= !xfer_dir;
              card_block_ready <= xfer_dir;
            end
          end
          HBD_HOST: begin
            if (host_end) begin
              ptr <= '0;
              state <= HBD_CARD;
              buffer_write_enable <= 1'b0;
              buffer_read_enable <= 1'b0;
              card_block_ready <= 1'b1;
            end else if (win_fire) begin
              ptr <= ptr_sum;
            end
          end
          HBD_CARD: begin
            if (card_fire && dir == HBD_DIR_WRITE) begin
              card_drain_data <= buf_mem[card_ptr[PW-2:0]];
            end
            if (card_end) begin
              card_ptr <= '0;
              state <= HBD_HOST;
              buffer_write_enable <= (dir == HBD_DIR_WRITE);
              buffer_read_enable <= (dir == HBD_DIR_READ);
              card_block_ready <= 1'b0;
            end else if (card_fire) begin
              card_ptr <= card_ptr + 1'b1;
            end
          end
          default: state <= HBD_IDLE;
        endcase
      end
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_len_protect: assert property (data_line_in_use |=> blk_len == $past(blk_len))
    else $error("block length changed while data line in use");
  a_wen_drop: assert property (host_end && win_write && !data_line_reset && !halt_now
      |=> !buffer_write_enable && card_block_ready)
    else $error("write space flag did not drop at block end");
  a_ren_drop: assert property (host_end && !win_write && !data_line_reset && !halt_now
      |=> !buffer_read_enable && card_block_ready)
    else $error("read data flag did not drop at block end");
  a_ptr_advance: assert property (win_fire && !host_end && !data_line_reset && !halt_now
      |=> ptr == $past(ptr) + $past(adv))
    else $error("pointer did not advance by bytes moved");
  a_ptr_zero: assert property ($rose(buffer_write_enable) || $rose(buffer_read_enable)
      |-> ptr == '0)
    else $error("block did not start at byte zero");
  a_ptr_bound: assert property (state == HBD_HOST |-> ptr < eff_len)
    else $error("pointer beyond block length");
  a_bad_pattern: assert property (win_sel && !pattern_ok && state == HBD_HOST
      && !data_line_reset && !halt_now |=> ptr == $past(ptr))
    else $error("unsupported lane pattern moved pointer");
  a_ack_answer: assert property (win_sel |=> win_ack)
    else $error("window access not answered");
  a_halt_df0: assert property (halt_now |=> xfer_halted && !buffer_write_enable
      && !buffer_read_enable && state == HBD_IDLE)
    else $error("resume flag zero did not halt transfer");
  a_int_cycle: assert property (halt_now && resume_4bit_mode
      |=> int_cycle_start ##1 int_cycle_start == $past(halt_now && resume_4bit_mode))
    else $error("interrupt cycle not started for 4-bit resume");
endmodule

// [logic/hbd_lane_decode.sv]
// Lane decoder: maps address bits and lane selects onto the 4-byte window.
// Assumes inputs already qualified as a window access.
`timescale 1ns/1ps
module hbd_lane_decode #(
  parameter int BUS_WIDTH = 32
) (
  // Bus access fields
  input wire logic [2:0] win_addr,
  input wire logic [3:0] byte_lane_select,
  input wire logic [31:0] win_wdata,
  // Decoded view
  output logic [3:0] lane_mask,
  output logic [1:0] lane_first,
  output logic [2:0] lane_count,
  output logic [1:0] data_shift,
  output logic [31:0] lane_wdata,
  output logic pattern_ok
);
  import hbd_pkg::*;

  wire narrow8 = (BUS_WIDTH == HBD_BUS_8);
  wire narrow16 = (BUS_WIDTH == HBD_BUS_16);
  wire [3:0] mask16 = {2'b00, byte_lane_select[1:0]} << {win_addr[1], 1'b0};

  // Position per bus width; all lane selects ignored on byte bus
  assign lane_mask = narrow8 ? (4'h1 << win_addr[1:0]) :
                     narrow16 ? mask16 : byte_lane_select;
  assign data_shift = narrow8 ? win_addr[1:0] : narrow16 ? {win_addr[1], 1'b0} : 2'b00;
  assign lane_wdata = win_wdata << {data_shift, 3'b000};

  // Accepted patterns and their sizes
  always_comb begin
    pattern_ok = 1'b1;
    lane_first = 2'b00;
    lane_count = HBD_CNT_1;
    case (lane_mask)
      HBD_BE_ALL: lane_count = HBD_CNT_4;
      HBD_BE_LO: lane_count = HBD_CNT_2;
      HBD_BE_HI: begin
        lane_count = HBD_CNT_2;
        lane_first = 2'b10;
      end
      HBD_BE_L0: lane_first = 2'b00;
      HBD_BE_L1: lane_first = 2'b01;
      HBD_BE_L2: lane_first = 2'b10;
      HBD_BE_L3: lane_first = 2'b11;
      default: begin
        pattern_ok = 1'b0;
        lane_count = HBD_CNT_0;
      end
    endcase
  end
endmodule
